// ==== rtl/mbpa_pkg.sv ====
package mbpa_pkg;
  localparam int NUM_SLOTS = 6;
  localparam int SLOT_W    = 3;
  // chain order, highest first: slot 6, 7, 2, 3, 4, 5
  localparam logic [SLOT_W-1:0] CHAIN_POS0 = 3'h6;
  localparam logic [SLOT_W-1:0] CHAIN_POS1 = 3'h7;
  localparam logic [SLOT_W-1:0] CHAIN_POS2 = 3'h2;
  localparam logic [SLOT_W-1:0] CHAIN_POS3 = 3'h3;
  localparam logic [SLOT_W-1:0] CHAIN_POS4 = 3'h4;
  localparam logic [SLOT_W-1:0] CHAIN_POS5 = 3'h5;
  localparam int SERIAL_POS = 5;
  localparam logic [SLOT_W-1:0] NO_SLOT = 3'h0;

  typedef enum logic [2:0] {
    GRANT_NONE,
    GRANT_CPU,
    GRANT_MEMREF,
    GRANT_VIDREF,
    GRANT_PERIPH
  } mbpa_owner_e;
endpackage

// ==== rtl/mbpa_chain_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mbpa_chain_if;
  logic [5:0] req;
  logic       upper_busy;
  logic [5:0] inhibit_in;
  logic [5:0] win;

  modport core  (output req, output upper_busy,
                 input inhibit_in, input win);
  modport chain (input req, input upper_busy,
                 output inhibit_in, output win);
endinterface
`default_nettype wire

// ==== rtl/mbpa_chain.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbpa_chain (
  mbpa_chain_if.chain ch
);
  import mbpa_pkg::*;

  // ripple through chain positions; any upstream request inhibits the rest
  always_comb begin
    logic run;
    run = ch.upper_busy;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      ch.inhibit_in[i] = run;
      ch.win[i]        = ch.req[i] && !run;
      run              = run || ch.req[i];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/mbpa_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbpa_arbiter (
  input  wire logic                          clock_i,
  input  wire logic                          srst_i,
  input  wire logic                          cycle_start_i,
  input  wire logic                          cpu_req_i,
  input  wire logic                          memref_req_i,
  input  wire logic                          vidref_req_i,
  input  wire logic                          kbd_pending_i,
  input  wire logic [mbpa_pkg::NUM_SLOTS-1:0] slot_req_i,
  output logic                               cpu_grant_o,
  output logic                               memref_grant_o,
  output logic                               vidref_grant_o,
  output logic                               kbd_strobe_o,
  output logic [mbpa_pkg::NUM_SLOTS-1:0]     slot_grant_o,
  output logic [mbpa_pkg::NUM_SLOTS-1:0]     slot_inhibit_o,
  output logic                               serial_enable_o,
  output logic [mbpa_pkg::SLOT_W-1:0]        granted_slot_o,
  output logic                               cpu_line_o,
  output logic                               memref_line_o,
  output logic                               vidref_line_o
);
  import mbpa_pkg::*;

  typedef struct packed {
    mbpa_owner_e          owner;
    logic                 cpu_grant;
    logic                 memref_grant;
    logic                 vidref_grant;
    logic [NUM_SLOTS-1:0] slot_grant;
    logic [NUM_SLOTS-1:0] slot_inhibit;
    logic                 serial_enable;
    logic [SLOT_W-1:0]    slot_num;
    logic                 kbd_strobe;
    logic                 cpu_line;
    logic                 memref_line;
    logic                 vidref_line;
  } mbpa_state_s;

  // every field cleared, so all outputs read low straight after reset
  localparam mbpa_state_s ST_IDLE = '{
    owner:         GRANT_NONE,
    cpu_grant:     1'b0,
    memref_grant:  1'b0,
    vidref_grant:  1'b0,
    slot_grant:    '0,
    slot_inhibit:  '0,
    serial_enable: 1'b0,
    slot_num:      NO_SLOT,
    kbd_strobe:    1'b0,
    cpu_line:      1'b0,
    memref_line:   1'b0,
    vidref_line:   1'b0
  };

  mbpa_state_s          st;
  mbpa_state_s          next_st;
  // decision that the coming cycle start would take
  mbpa_owner_e          next_owner;
  logic                 any_win;
  logic [NUM_SLOTS-1:0] next_win;

  mbpa_chain_if chain_bus ();

  mbpa_chain u_chain (
    .ch (chain_bus.chain)
  );

  function automatic logic [SLOT_W-1:0] pos_to_slot(input int pos);
    logic [SLOT_W-1:0] s;
    s = NO_SLOT;
    unique case (pos)
      0: s = CHAIN_POS0;
      1: s = CHAIN_POS1;
      2: s = CHAIN_POS2;
      3: s = CHAIN_POS3;
      4: s = CHAIN_POS4;
      5: s = CHAIN_POS5;
      default: s = NO_SLOT;
    endcase
    return s;
  endfunction

  // grant lines of the three fixed requesters: {cpu, memory, video}
  function automatic logic [2:0] owner_grants(input mbpa_owner_e o);
    logic [2:0] g;
    g = 3'h0;
    unique case (o)
      GRANT_NONE:   g = 3'h0;
      GRANT_CPU:    g = 3'h4;
      GRANT_MEMREF: g = 3'h2;
      GRANT_VIDREF: g = 3'h1;
      GRANT_PERIPH: g = 3'h0;
      default:      g = 3'h0;
    endcase
    return g;
  endfunction

  // fixed ranking above the chain; the chain only wins when all are idle
  function automatic mbpa_owner_e pick_owner(
    input logic cpu,
    input logic memref,
    input logic vidref,
    input logic periph
  );
    mbpa_owner_e o;
    o = GRANT_NONE;
    if (cpu) begin
      o = GRANT_CPU;
    end else if (memref) begin
      o = GRANT_MEMREF;
    end else if (vidref) begin
      o = GRANT_VIDREF;
    end else if (periph) begin
      o = GRANT_PERIPH;
    end
    return o;
  endfunction

  // slot number of the single winning position, NO_SLOT when none
  function automatic logic [SLOT_W-1:0] win_to_slot(
    input logic [NUM_SLOTS-1:0] win
  );
    logic [SLOT_W-1:0] s;
    s = NO_SLOT;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (win[i]) begin
        s = pos_to_slot(i);
      end
    end
    return s;
  endfunction

  // chain winners count only when nobody above the chain was chosen
  function automatic logic [NUM_SLOTS-1:0] periph_grant(
    input mbpa_owner_e          o,
    input logic [NUM_SLOTS-1:0] win
  );
    logic [NUM_SLOTS-1:0] g;
    g = '0;
    if (o == GRANT_PERIPH) begin
      g = win;
    end
    return g;
  endfunction

  // chain inputs are indexed by position: slot_req_i[0] is slot 6
  assign chain_bus.req        = slot_req_i;
  // processor, memory and video refresh all sit above the chain
  assign chain_bus.upper_busy = cpu_req_i || memref_req_i || vidref_req_i;
  assign any_win              = |chain_bus.win;
  assign next_owner           = pick_owner(cpu_req_i, memref_req_i,
                                           vidref_req_i, any_win);
  assign next_win             = periph_grant(next_owner, chain_bus.win);

  always_comb begin
    next_st              = st;
    next_st.cpu_line     = cpu_req_i;
    next_st.memref_line  = memref_req_i;
    next_st.vidref_line  = vidref_req_i;
    next_st.slot_inhibit = chain_bus.inhibit_in;
    next_st.kbd_strobe   = 1'b0;

    if (cycle_start_i) begin
      // decisions only at cycle start: a grant holds the whole memory cycle
      next_st.owner = next_owner;
      {next_st.cpu_grant, next_st.memref_grant, next_st.vidref_grant} =
        owner_grants(next_owner);

      // keyboard rides the video cycle and never asks on its own
      next_st.kbd_strobe = (next_owner == GRANT_VIDREF) &&
                           kbd_pending_i;

      next_st.slot_grant    = next_win;
      next_st.slot_num      = win_to_slot(next_win);
      next_st.serial_enable = next_win[SERIAL_POS];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // every output is a plain flip-flop copy
  assign cpu_grant_o     = st.cpu_grant;
  assign memref_grant_o  = st.memref_grant;
  assign vidref_grant_o  = st.vidref_grant;

  // peripheral side
  assign kbd_strobe_o    = st.kbd_strobe;
  assign slot_grant_o    = st.slot_grant;
  assign slot_inhibit_o  = st.slot_inhibit;
  // serial interface may drive only during its own grant
  assign serial_enable_o = st.serial_enable;
  assign granted_slot_o  = st.slot_num;

  // request lines fanned out to the card positions
  assign cpu_line_o      = st.cpu_line;
  assign memref_line_o   = st.memref_line;
  assign vidref_line_o   = st.vidref_line;
endmodule
`default_nettype wire

// ==== tb/mbpa_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbpa_checker (
  input wire logic       clock_i,
  input wire logic       srst_i,
  input wire logic       cycle_start_i,
  input wire logic       cpu_req_i,
  input wire logic       memref_req_i,
  input wire logic       vidref_req_i,
  input wire logic       cpu_grant_o,
  input wire logic       memref_grant_o,
  input wire logic       vidref_grant_o,
  input wire logic       kbd_strobe_o,
  input wire logic       serial_enable_o,
  input wire logic [5:0] slot_grant_o,
  input wire logic [5:0] slot_inhibit_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  wire logic cs = cycle_start_i;
  wire logic hi = cpu_req_i | memref_req_i;
  cpu_top_a: assert property (cs && cpu_req_i |=> cpu_grant_o)
    else $error("cpu lost");
  mem_next_a: assert property (
    cs && !cpu_req_i && memref_req_i |=> memref_grant_o) else $error("mem");
  vid_third_a: assert property (
    cs && !hi && vidref_req_i |=> vidref_grant_o && !slot_grant_o)
    else $error("vid");
  serial_inh_a: assert property (vidref_req_i |=> slot_inhibit_o[5])
    else $error("serial inhibit");
  kbd_ride_a: assert property (kbd_strobe_o |-> vidref_grant_o)
    else $error("kbd strobe");
  serial_en_a: assert property (serial_enable_o == slot_grant_o[5])
    else $error("serial enable");
  one_owner_a: assert property ($onehot0({cpu_grant_o, memref_grant_o,
    vidref_grant_o, slot_grant_o})) else $error("two owners");
  grant_hold_a: assert property (!cs |=> $stable(slot_grant_o))
    else $error("grant moved");
  cover property (kbd_strobe_o);
  cover property (serial_enable_o);
  cover property (cpu_grant_o && !cs);
endmodule
bind mbpa_arbiter mbpa_checker u_chk (.*);
`default_nettype wire

// ==== tb/mbpa_requester.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbpa_requester (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic raise_i,
  input  wire logic grant_i,
  output logic      req_o
);
  // a loser keeps asking until it is served
  always_ff @(posedge clock_i)
    if (srst_i || grant_i) req_o <= 1'b0;
    else if (raise_i) req_o <= 1'b1;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clock_i = 1'b0;
  logic       srst_i  = 1'b1;
  logic       cs      = 1'b0;
  logic       kbd     = 1'b0;
  logic [8:0] raise   = '0;
  wire logic [8:0] req, gnt;
  logic [5:0] inh;
  logic [2:0] gs;
  logic       cl, ml, vl, ks, se;
  int         n_fail  = 0;
  int         n_tests = 0;
  logic [2:0] num [6] = '{3'h6, 3'h7, 3'h2, 3'h3, 3'h4, 3'h5};
  mbpa_requester u_req[8:0] (.clock_i, .srst_i, .raise_i(raise),
    .grant_i(gnt), .req_o(req));
  mbpa_arbiter dut (.clock_i, .srst_i, .cycle_start_i(cs),
    .cpu_req_i(req[0]), .memref_req_i(req[1]), .vidref_req_i(req[2]),
    .kbd_pending_i(kbd), .slot_req_i(req[8:3]), .cpu_grant_o(gnt[0]),
    .memref_grant_o(gnt[1]), .vidref_grant_o(gnt[2]), .kbd_strobe_o(ks),
    .slot_grant_o(gnt[8:3]), .slot_inhibit_o(inh), .serial_enable_o(se),
    .granted_slot_o(gs), .cpu_line_o(cl), .memref_line_o(ml),
    .vidref_line_o(vl));
  initial forever #20 clock_i = ~clock_i;
  task automatic chk(string s, logic [8:0] got, logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_idle();
    kbd = 1'b1;
    cs  = 1'b1;
    @(negedge clock_i) cs = 1'b0;
    chk("idle", gnt | 9'(ks), '0);
  endtask
  // everyone asks at once, then one winner per cycle in rank order
  task automatic t_prio();
    logic [5:0] e;
    @(negedge clock_i) raise = '1;
    @(negedge clock_i) raise = '0;
    for (int i = 0; i < 9; i++) begin
      cs = 1'b1;
      @(negedge clock_i) cs = 1'b0;
      chk("grant", gnt, 9'h001 << i);
      chk("kbd", 9'({ks, se}), 9'({i == 2, i == 8}));
      chk("line", 9'({cl, ml, vl}), 9'({i < 1, i < 2, i < 3}));
      e = 6'h3f << (i > 2 ? i - 2 : 0);
      chk("inh", 9'(inh), 9'(e));
      chk("slot", 9'(gs), 9'(i > 2 ? num[i - 3] : 3'h0));
      @(negedge clock_i);
    end
  endtask
  initial begin
    repeat (16) @(negedge clock_i);
    srst_i = 1'b0;
    chk("reset", gnt, '0);
    t_idle();
    t_prio();
    conclude();
  end
endmodule
`default_nettype wire
